// [hdl/capture_timer_16bit.v]
// Functional notes
// - 16-bit counter increments on each tick
// - prescale 1/4/16/64, ignored for external clock
// - source bit picks internal or external clock
// - task field 0 none, 1-4 request task
// - free mode: wrap sets event flag
// - mode 1: rising edge captures, sets event
// - mode 2: falling edge captures, sets event
// - event flag auto-clears if task 1-4, else read
// - wrap flag set every wrap, read clears
// - software reads and loads running counter anytime
// - counter wraps at programmable 16-bit limit
// - capture register holds latest captured count
// - capture event can schedule selected task
`timescale 1ns/1ps
`include "capture_timer_consts.vh"

module capture_timer_16bit (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [4:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg         err_o,
    // pins
    input  wire        capture_edge_input_i,
    input  wire        external_count_clock_input_i,
    // events
    output reg  [2:0]  event_task_o,
    output reg         event_task_req_o,
    output reg         irq_o
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg  [12:0] timer_control_word;
    reg  [1:0]  timer_status_word;
    reg  [15:0] timer_count_value;
    reg  [15:0] timer_wrap_limit;
    reg  [15:0] timer_capture_value;
    reg  [1:0]  irq_mask;
    reg  [5:0]  pre_cnt;
    reg  [2:0]  cap_sync;
    reg  [2:0]  ext_sync;
    reg         cap_level;
    reg         ext_level;

    wire [2:0]  task_sel  = timer_control_word[`CTL_TASK_MSB:`CTL_TASK_LSB];
    wire        enable    = timer_control_word[`CTL_EN_BIT];
    wire        ext_src   = timer_control_word[`CTL_SRC_BIT];
    wire [1:0]  pre_sel   = timer_control_word[`CTL_PRE_MSB:`CTL_PRE_LSB];
    wire [1:0]  mode      = timer_control_word[`CTL_MODE_MSB:`CTL_MODE_LSB];

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire        req       = cyc_i & stb_i & ~ack_o & ~err_o;
    wire [4:0]  byte_adr  = {adr_i[4:2], 2'b00};
    wire        hit_ctl   = (byte_adr == {1'b0, `ADDR_CONTROL});
    wire        hit_st    = (byte_adr == {1'b0, `ADDR_STATUS});
    wire        hit_cnt   = (byte_adr == {1'b0, `ADDR_COUNT});
    wire        hit_lim   = (byte_adr == {1'b0, `ADDR_LIMIT});
    wire        hit_cap   = (byte_adr == {`SEL_MASK_REG, `ADDR_CONTROL});
    wire        hit_msk   = (byte_adr == {`SEL_MASK_REG, `ADDR_STATUS});
    wire        hit_any   = hit_ctl | hit_st | hit_cnt | hit_lim | hit_cap | hit_msk;
    wire        wr        = req & we_i & hit_any;
    wire        st_read   = req & ~we_i & hit_st;

    // byte-lane merge for 16-bit registers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        begin
            merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
        end
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers and edges
    // ---------------------------------------------------------------
    // a change counts only once stages two and three agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            cap_sync  <= 3'h0;
            ext_sync  <= 3'h0;
            cap_level <= 1'b0;
            ext_level <= 1'b0;
        end else begin
            cap_sync <= {cap_sync[1:0], capture_edge_input_i};
            ext_sync <= {ext_sync[1:0], external_count_clock_input_i};
            if (cap_sync[1] == cap_sync[2])
                cap_level <= cap_sync[2];
            if (ext_sync[1] == ext_sync[2])
                ext_level <= ext_sync[2];
        end
    end

    wire cap_rise = (cap_sync[1] == cap_sync[2]) & cap_sync[2] & ~cap_level;
    wire cap_fall = (cap_sync[1] == cap_sync[2]) & ~cap_sync[2] & cap_level;
    // external clock counts on its rising edge; 600 kHz leaves ample margin
    wire ext_tick = (ext_sync[1] == ext_sync[2]) & ext_sync[2] & ~ext_level;

    // ---------------------------------------------------------------
    // tick generation
    // ---------------------------------------------------------------
    reg  [5:0] pre_max;
    always @* begin
        case (pre_sel)
            `PRE_DIV1:  pre_max = 6'h00;
            `PRE_DIV4:  pre_max = `PRE_MAX_DIV4;
            `PRE_DIV16: pre_max = `PRE_MAX_DIV16;
            default:    pre_max = `PRE_MAX_DIV64;
        endcase
    end

    wire int_tick = (pre_cnt >= pre_max);
    wire tick     = enable & (ext_src ? ext_tick : int_tick);
    wire at_limit = (timer_count_value == timer_wrap_limit);
    wire wrap     = tick & at_limit;
    wire cap_evt  = ((mode == `MODE_CAP_RISE) & cap_rise) |
                    ((mode == `MODE_CAP_FALL) & cap_fall);
    wire evt      = cap_evt | ((mode == `MODE_FREE) & wrap);
    wire task_on  = (task_sel != `TASK_NONE) & (task_sel <= `TASK_MAX);

    always @(posedge clk_i) begin
        if (rst_i | ~enable | ext_src)
            pre_cnt <= 6'h00;
        else if (int_tick)
            pre_cnt <= 6'h00;
        else
            pre_cnt <= pre_cnt + 6'h01;
    end

    // ---------------------------------------------------------------
    // counter, capture and control registers
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_control_word  <= 13'h0000;
            timer_count_value   <= 16'h0000;
            timer_wrap_limit    <= 16'hFFFF;
            timer_capture_value <= 16'h0000;
            irq_mask            <= 2'h0;
        end else begin
            // a software load beats a tick in the same cycle
            if (wr & hit_cnt)
                timer_count_value <= merge16(timer_count_value, dat_i, sel_i);
            else if (wrap)
                timer_count_value <= 16'h0000;
            else if (tick)
                timer_count_value <= timer_count_value + 16'h0001;
            if (wr & hit_cap)
                timer_capture_value <= merge16(timer_capture_value, dat_i, sel_i);
            else if (cap_evt)
                timer_capture_value <= timer_count_value;
            if (wr & hit_lim)
                timer_wrap_limit <= merge16(timer_wrap_limit, dat_i, sel_i);
            if (wr & hit_ctl) begin
                if (sel_i[0])
                    timer_control_word[7:0] <= dat_i[7:0];
                if (sel_i[1])
                    timer_control_word[12:8] <= dat_i[12:8];
            end
            if (wr & hit_msk & sel_i[0])
                irq_mask <= dat_i[1:0];
        end
    end

    // ---------------------------------------------------------------
    // status flags, events and bus answer
    // ---------------------------------------------------------------
    // set wins over clear-on-read for both flags
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_status_word <= 2'h0;
            event_task_o      <= `TASK_NONE;
            event_task_req_o  <= 1'b0;
            irq_o             <= 1'b0;
            ack_o             <= 1'b0;
            err_o             <= 1'b0;
            dat_o             <= 32'h0000_0000;
        end else begin
            if (evt & ~task_on)
                timer_status_word[`ST_EVENT_BIT] <= 1'b1;
            else if (task_on | st_read)
                timer_status_word[`ST_EVENT_BIT] <= 1'b0;
            if (wrap)
                timer_status_word[`ST_WRAP_BIT] <= 1'b1;
            else if (st_read)
                timer_status_word[`ST_WRAP_BIT] <= 1'b0;
            // with a task selected the flag is consumed here as a request pulse
            event_task_req_o <= evt & task_on;
            event_task_o     <= task_on ? task_sel : `TASK_NONE;
            irq_o            <= |(timer_status_word & irq_mask);
            ack_o            <= req & hit_any;
            err_o            <= req & ~hit_any;
            dat_o            <= 32'h0000_0000;
            if (req & ~we_i) begin
                if (hit_ctl)
                    dat_o <= {19'h0, timer_control_word};
                if (hit_st)
                    dat_o <= {30'h0, timer_status_word};
                if (hit_cnt)
                    dat_o <= {16'h0, timer_count_value};
                if (hit_lim)
                    dat_o <= {16'h0, timer_wrap_limit};
                if (hit_cap)
                    dat_o <= {16'h0, timer_capture_value};
                if (hit_msk)
                    dat_o <= {30'h0, irq_mask};
            end
        end
    end

endmodule // capture_timer_16bit

// [hdl/capture_timer_consts.vh]
`ifndef CAPTURE_TIMER_CONSTS_VH
`define CAPTURE_TIMER_CONSTS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ADDR_CONTROL      4'h0
`define ADDR_STATUS       4'h4
`define ADDR_COUNT        4'h8
`define ADDR_LIMIT        4'hC
`define ADDR_MASK_HI      4'h0
`define SEL_MASK_REG      1'b1

// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define CTL_WIDTH         13
`define CTL_TASK_LSB      0
`define CTL_TASK_MSB      2
`define CTL_EN_BIT        3
`define CTL_SRC_BIT       4
`define CTL_PRE_LSB       5
`define CTL_PRE_MSB       6
`define CTL_MODE_LSB      7
`define CTL_MODE_MSB      8

// ---------------------------------------------------------------
// modes, prescale and status
// ---------------------------------------------------------------
`define MODE_FREE         2'h0
`define MODE_CAP_RISE     2'h1
`define MODE_CAP_FALL     2'h2
`define PRE_DIV1          2'h0
`define PRE_DIV4          2'h1
`define PRE_DIV16         2'h2
`define PRE_MAX_DIV4      6'h03
`define PRE_MAX_DIV16     6'h0F
`define PRE_MAX_DIV64     6'h3F
`define TASK_NONE         3'h0
`define TASK_MAX          3'h4
`define ST_EVENT_BIT      0
`define ST_WRAP_BIT       1

`endif

// [tb/capture_timer_16bit_sva.sv]
`timescale 1ns/1ps
module capture_timer_16bit_sva (
    // clock, reset, bus
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [4:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        err_o,
    // pins and events
    input wire        capture_edge_input_i,
    input wire        external_count_clock_input_i,
    input wire [2:0]  event_task_o,
    input wire        event_task_req_o,
    input wire        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = cyc_i && stb_i && !ack_o && !err_o;
    a_bus_answer: assert property (req |=> ack_o ^ err_o) else $error("no single answer");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_err_pulse: assert property (err_o |=> !err_o) else $error("err held");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
    a_err_unmapped: assert property (req && adr_i[4:2] > 3'h5 |=> err_o) else $error("no err");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data not zero");
    a_count_width: assert property (ack_o && $past(adr_i[4:2] == 3'h2)
        |-> dat_o[31:16] == 16'h0) else $error("count wider");
    a_task_range: assert property (event_task_o <= 3'h4) else $error("bad task");
    a_task_req: assert property (event_task_req_o |-> event_task_o != 3'h0) else $error("no task");
endmodule // capture_timer_16bit_sva

bind capture_timer_16bit capture_timer_16bit_sva chk_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .capture_edge_input_i,
    .external_count_clock_input_i, .event_task_o, .event_task_req_o, .irq_o);

// [tb/pin_source.sv]
`timescale 1ns/1ps
module pin_source (
    input  wire  clk_i,
    output logic cap_o,
    output logic ext_o
);
    initial begin
        cap_o = 0;
        ext_o = 0;
    end
    // 80-cycle period stays under 600 kHz; the clock idles low between bursts
    task ext_ticks(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (40) @(posedge clk_i);
            ext_o <= 1;
            repeat (40) @(posedge clk_i);
            ext_o <= 0;
        end
    endtask
    // held long enough to pass the input filter
    task cap_level(input logic v);
        @(posedge clk_i);
        cap_o <= v;
        repeat (12) @(posedge clk_i);
    endtask
endmodule // pin_source

// [tb/tb_capture_timer_16bit.sv]
`timescale 1ns/1ps
module tb_capture_timer_16bit;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, cap, ext, last_err, seen, ack_o, err_o;
    logic        req_o, irq_o;
    logic [4:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [2:0]  task_o;
    int          error_cnt = 0, n_tests = 0, cnt = 0, t0;
    localparam logic [4:0] A_CTL = 5'h00, A_ST = 5'h04, A_CNT = 5'h08, A_LIM = 5'h0C;
    localparam logic [4:0] A_CAP = 5'h10, A_MSK = 5'h14;
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
    capture_timer_16bit capture_timer_16bit_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .capture_edge_input_i(cap),
        .external_count_clock_input_i(ext), .event_task_o(task_o),
        .event_task_req_o(req_o), .irq_o(irq_o));
    pin_source pin_source_inst (.clk_i, .cap_o(cap), .ext_o(ext));
    initial begin
        clk_i = 0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        if (req_o) seen <= 1;
    end
    task final_report;
        if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // request held until the edge that samples the answer
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
        do @(posedge clk_i); while (!(ack_o || err_o));
        q = dat_o;
        last_err = err_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
        @(posedge clk_i);
    endtask
    task t_reset;
        wb(0, A_LIM, 0); `CHK("limit", 32'hFFFF, q)
        wb(0, 5'h18, 0); `CHK("unmapped err", 1'b1, last_err)
        wb(1, A_CNT, 32'h1234); repeat (20) @(posedge clk_i);
        wb(0, A_CNT, 0); `CHK("held count", 32'h1234, q)
        sel_i <= 4'h1; wb(1, A_CNT, 32'hAB77); sel_i <= 4'hF;
        wb(0, A_CNT, 0); `CHK("low lane load", 32'h1277, q)
        sel_i <= 4'h2; wb(1, A_CNT, 32'hAB77); sel_i <= 4'hF;
        wb(0, A_CNT, 0); `CHK("high lane load", 32'hAB77, q)
        wb(1, A_CNT, 32'h1234);
    endtask
    task t_prescale;
        for (int p = 0; p < 4; p++) begin
            wb(1, A_CNT, 0); wb(1, A_CTL, 32'h8 | (p << 5)); t0 = cnt;
            repeat (640) @(posedge clk_i);
            wb(1, A_CTL, 0); t0 = (cnt - t0) >> (2 * p); wb(0, A_CNT, 0);
            `CHK("prescale", 1'b1, q + 1 >= t0 && q <= t0 + 1)
        end
    endtask
    task t_capture;
        wb(1, A_CTL, 32'hF8); wb(1, A_CNT, 32'h321); pin_source_inst.cap_level(1);
        wb(0, A_CAP, 0); `CHK("rise capture", 32'h321, q)
        wb(0, A_ST, 0); `CHK("event status", 32'h1, q)
        pin_source_inst.ext_ticks(5);
        wb(0, A_CNT, 0); `CHK("ext count", 32'h326, q)
        wb(1, A_CTL, 32'h178); pin_source_inst.cap_level(0); wb(1, A_CNT, 32'h456);
        pin_source_inst.cap_level(1);
        wb(0, A_CAP, 0); `CHK("rise ignored", 32'h326, q)
        pin_source_inst.cap_level(0);
        wb(0, A_CAP, 0); `CHK("fall capture", 32'h456, q)
    endtask
    task t_task;
        wb(0, A_ST, 0); wb(1, A_CTL, 32'hFA); seen = 0; pin_source_inst.cap_level(1);
        `CHK("task req", 1'b1, seen)
        `CHK("task code", 3'h2, task_o)
        wb(0, A_ST, 0); `CHK("auto clear", 32'h0, q)
    endtask
    task t_wrap;
        wb(1, A_CTL, 0); wb(1, A_MSK, 0); wb(1, A_LIM, 32'h5); wb(1, A_CNT, 32'h5);
        wb(0, A_ST, 0);
        wb(1, A_CTL, 32'h68);
        repeat (80) @(posedge clk_i); `CHK("masked irq", 1'b0, irq_o)
        wb(1, A_MSK, 32'h3); repeat (3) @(posedge clk_i); `CHK("irq", 1'b1, irq_o)
        wb(0, A_ST, 0); `CHK("wrap status", 32'h3, q)
        wb(0, A_CNT, 0); `CHK("wrapped count", 1'b1, q < 2)
        repeat (3) @(posedge clk_i); `CHK("irq clear", 1'b0, irq_o)
        wb(0, A_ST, 0); `CHK("read clear", 32'h0, q)
    endtask
    initial begin
        rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0; dat_i = 0; sel_i = 4'hF; seen = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        t_reset; t_prescale; t_capture; t_task; t_wrap;
        final_report;
    end
    // the tests need about 3300 cycles
    initial begin
        #500000;
        error_cnt++;
        final_report;
    end
endmodule // tb_capture_timer_16bit
